// file: design/usbs_sfr_bank.sv
// USB special-function-register bank: window decode, buffer data port, offset pointer, summary flags.
// Assumes the CPU bus is on sys_clk, one access per cycle, and USB engine events are on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "usbs_params.svh"

// Overview of operation
// - With select = device block, window C1..C7 holds control, power-down, irq enable, irq request, reserved, frame low, frame high.
// - With select top bit zero, low three bits pick endpoint 0..4 whose six registers sit at C1..C6, C7 reserved.
// - A data-port write stores the byte in buffer memory at endpoint base plus offset.
// - A data-port read returns the byte held in the data port, fetched at the last offset change.
// - A data-port write takes effect only with direction 0 and buffer-full 1, or direction 1 and buffer-full 0.
// - A data-port read or write that fails the direction and buffer-full gating raises the no-data fault flag.
// - Buffer memory is paged in 128 bytes, packets reach 64 bytes, and only six offset bits address it.
// - An offset-pointer write is accepted only under the same direction and buffer-full gating.
// - The two upper offset-pointer bits always read zero.
// - Each offset change, automatic or written, fetches the newly addressed byte into the data port.
// - The summary register holds one flag per endpoint, set when any of its eight requests becomes active.
// - An endpoint summary flag clears when the CPU reads that endpoint's irq request register.
// - Summary bit 7 is the device-request flag, never cleared by hardware.
// - The device-request flag clears only on a software write of zero; writing one leaves it.
// - The device register block is reachable only while select holds 80 hex.
module usbs_sfr_bank (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire usbs_pkg::usbs_sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    input wire usbs_pkg::usbs_ep_state_type ep_state,
    input wire logic [`USBS_EP_COUNT-1:0][7:0] ep_irq_set,
    input wire logic [7:0] dev_irq_set,
    input wire logic dev_req_set,
    input wire logic [15:0] frame_number,
    output logic [`USBS_EP_COUNT-1:0][7:0] ep_buffer_control,
    output logic [`USBS_EP_COUNT-1:0][7:0] ep_buffer_status,
    output logic [`USBS_EP_COUNT-1:0][7:0] ep_irq_enable,
    output logic [`USBS_EP_COUNT-1:0][7:0] ep_buffer_length,
    output logic [7:0] device_control,
    output logic [7:0] device_power_down,
    output logic [7:0] device_irq_enable,
    output logic [7:0] global_ep_irq_summary
);
    import usbs_pkg::*;

    // --------------------------------------------------------------------------
    // State
    // --------------------------------------------------------------------------
    logic [7:0] select_ff;
    logic [7:0] data_ff;
    logic [`USBS_OFF_BITS-1:0] offset_ff;
    logic fetch_pend_ff;
    logic dev_req_ff;
    logic [`USBS_EP_COUNT-1:0] summary_ff;
    logic [7:0] dev_ctl_ff, dev_pwr_ff, dev_ien_ff, dev_irq_ff;
    logic [7:0] ep_bc_ff [`USBS_EP_COUNT];
    logic [7:0] ep_bs_ff [`USBS_EP_COUNT];
    logic [7:0] ep_ie_ff [`USBS_EP_COUNT];
    logic [7:0] ep_ir_ff [`USBS_EP_COUNT];
    logic [7:0] ep_ba_ff [`USBS_EP_COUNT];
    logic [7:0] ep_len_ff [`USBS_EP_COUNT];

    // --------------------------------------------------------------------------
    // Block select decode
    // --------------------------------------------------------------------------
    wire dev_sel = (select_ff == `USBS_SELECT_DEVICE);
    wire [2:0] ep_num = select_ff[2:0];
    wire ep_sel = !select_ff[`USBS_SELECT_TOP] && (ep_num <= `USBS_EP_LAST);
    wire [2:0] ep_idx = ep_sel ? ep_num : 3'h0;
    wire wr_select = sfr_req.wr && (sfr_req.addr == `USBS_ADDR_SELECT);
    wire rd_data = sfr_req.rd && (sfr_req.addr == `USBS_ADDR_DATA);
    wire wr_data = sfr_req.wr && (sfr_req.addr == `USBS_ADDR_DATA);
    wire wr_offset = sfr_req.wr && (sfr_req.addr == `USBS_ADDR_OFFSET);
    wire wr_summary = sfr_req.wr && (sfr_req.addr == `USBS_ADDR_SUMMARY);
    wire dev_wr = dev_sel && sfr_req.wr;

    // --------------------------------------------------------------------------
    // Buffer access gating and addressing
    // --------------------------------------------------------------------------
    // Direction 0 needs buffer-full set, direction 1 needs it clear
    wire gate_ok = ep_sel && (ep_state.dir[ep_idx] != ep_state.cpu_buffer_full[ep_idx]);
    wire data_wr_ok = wr_data && gate_ok;
    wire data_rd_ok = rd_data && gate_ok;
    wire offset_wr_ok = wr_offset && gate_ok;
    wire fault_event = ep_sel && (rd_data || wr_data) && !gate_ok;
    // Base plus six-bit offset; the 64-byte packet limit keeps it inside a page
    wire [7:0] mem_addr = 8'(ep_ba_ff[ep_idx] + {2'b00, offset_ff});
    wire [7:0] mem_rdata;

    // Offset moves on an accepted write or after each successful data access
    wire offset_step = data_wr_ok || data_rd_ok;
    wire [`USBS_OFF_BITS-1:0] nxt_offset = offset_wr_ok ? sfr_req.wdata[`USBS_OFF_BITS-1:0] :
                                           offset_step ? offset_ff + `USBS_OFF_ONE : offset_ff;
    wire nxt_fetch_pend = offset_wr_ok || offset_step;

    usbs_buf_mem u_usbs_buf_mem (
        .sys_clk(sys_clk),
        .we(data_wr_ok),
        .addr(mem_addr),
        .wdata(sfr_req.wdata),
        .rdata(mem_rdata)
    );

    // --------------------------------------------------------------------------
    // Global registers
    // --------------------------------------------------------------------------
    // Device-request flag: event wins over a same-cycle clear, writing one keeps it
    wire nxt_dev_req = dev_req_set || (dev_req_ff && !(wr_summary && !sfr_req.wdata[`USBS_REQ_BIT]));

    // Select, pointer and prefetch
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            select_ff <= `USBS_SELECT_RESET;
            offset_ff <= '0;
            fetch_pend_ff <= 1'b0;
            data_ff <= `USBS_BYTE_ZERO;
            dev_req_ff <= 1'b0;
        end else begin
            if (wr_select) begin
                select_ff <= sfr_req.wdata & `USBS_SELECT_MASK;
            end
            offset_ff <= nxt_offset;
            fetch_pend_ff <= nxt_fetch_pend;
            if (fetch_pend_ff) begin
                data_ff <= mem_rdata;
            end
            dev_req_ff <= nxt_dev_req;
        end
    end

    // --------------------------------------------------------------------------
    // Device register block
    // --------------------------------------------------------------------------
    // Request bits: hardware set wins, software clears by writing zero
    wire [7:0] dev_irq_clear = (dev_wr && sfr_req.addr == `USBS_WIN_4) ? ~sfr_req.wdata : `USBS_BYTE_ZERO;
    wire [7:0] nxt_dev_irq = dev_irq_set | (dev_irq_ff & ~dev_irq_clear);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_ctl_ff <= `USBS_BYTE_ZERO;
            dev_pwr_ff <= `USBS_BYTE_ZERO;
            dev_ien_ff <= `USBS_BYTE_ZERO;
            dev_irq_ff <= `USBS_BYTE_ZERO;
        end else begin
            if (dev_wr && sfr_req.addr == `USBS_WIN_1) dev_ctl_ff <= sfr_req.wdata;
            if (dev_wr && sfr_req.addr == `USBS_WIN_2) dev_pwr_ff <= sfr_req.wdata;
            if (dev_wr && sfr_req.addr == `USBS_WIN_3) dev_ien_ff <= sfr_req.wdata;
            dev_irq_ff <= nxt_dev_irq;
        end
    end

    // --------------------------------------------------------------------------
    // Endpoint register blocks, one per endpoint
    // --------------------------------------------------------------------------
    logic [7:0] ep_ir_set_all [`USBS_EP_COUNT];
    genvar e;
    generate
        for (e = 0; e < `USBS_EP_COUNT; e++) begin : g_ep
            wire this_ep = ep_sel && (ep_num == 3'(e));
            wire ep_wr = this_ep && sfr_req.wr;
            wire ir_read = this_ep && sfr_req.rd && (sfr_req.addr == `USBS_WIN_4);
            wire [7:0] fault_set = (this_ep && fault_event) ? 8'(1 << `USBS_FAULT_BIT) : `USBS_BYTE_ZERO;
            wire [7:0] ir_set = ep_irq_set[e] | fault_set;
            wire [7:0] ir_clear = (ep_wr && sfr_req.addr == `USBS_WIN_4) ? ~sfr_req.wdata : `USBS_BYTE_ZERO;
            // A request becoming active wins over the read that clears the summary flag
            wire nxt_summary = (|ir_set) || (summary_ff[e] && !ir_read);
            assign ep_ir_set_all[e] = ir_set;

            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ep_bc_ff[e] <= `USBS_BYTE_ZERO;
                    ep_bs_ff[e] <= `USBS_BYTE_ZERO;
                    ep_ie_ff[e] <= `USBS_BYTE_ZERO;
                    ep_ir_ff[e] <= `USBS_BYTE_ZERO;
                    ep_ba_ff[e] <= `USBS_BYTE_ZERO;
                    ep_len_ff[e] <= `USBS_BYTE_ZERO;
                    summary_ff[e] <= 1'b0;
                end else begin
                    if (ep_wr && sfr_req.addr == `USBS_WIN_1) ep_bc_ff[e] <= sfr_req.wdata;
                    if (ep_wr && sfr_req.addr == `USBS_WIN_2) ep_bs_ff[e] <= sfr_req.wdata;
                    if (ep_wr && sfr_req.addr == `USBS_WIN_3) ep_ie_ff[e] <= sfr_req.wdata;
                    if (ep_wr && sfr_req.addr == `USBS_WIN_5) ep_ba_ff[e] <= sfr_req.wdata;
                    if (ep_wr && sfr_req.addr == `USBS_WIN_6) ep_len_ff[e] <= sfr_req.wdata;
                    ep_ir_ff[e] <= ir_set | (ep_ir_ff[e] & ~ir_clear);
                    summary_ff[e] <= nxt_summary;
                end
            end

            assign ep_buffer_control[e] = ep_bc_ff[e];
            assign ep_buffer_status[e] = ep_bs_ff[e];
            assign ep_irq_enable[e] = ep_ie_ff[e];
            assign ep_buffer_length[e] = ep_len_ff[e];
        end
    endgenerate

    // --------------------------------------------------------------------------
    // Read data selection
    // --------------------------------------------------------------------------
    // Reserved window slots and a non-device top-bit select read as zero
    wire [7:0] summary_value = {dev_req_ff, 2'b00, summary_ff};
    wire [7:0] dev_rdata = (sfr_req.addr == `USBS_WIN_1) ? dev_ctl_ff :
                           (sfr_req.addr == `USBS_WIN_2) ? dev_pwr_ff :
                           (sfr_req.addr == `USBS_WIN_3) ? dev_ien_ff :
                           (sfr_req.addr == `USBS_WIN_4) ? dev_irq_ff :
                           (sfr_req.addr == `USBS_WIN_6) ? frame_number[7:0] :
                           (sfr_req.addr == `USBS_WIN_7) ? frame_number[15:8] : `USBS_BYTE_ZERO;
    wire [7:0] ep_rdata = (sfr_req.addr == `USBS_WIN_1) ? ep_bc_ff[ep_idx] :
                          (sfr_req.addr == `USBS_WIN_2) ? ep_bs_ff[ep_idx] :
                          (sfr_req.addr == `USBS_WIN_3) ? ep_ie_ff[ep_idx] :
                          (sfr_req.addr == `USBS_WIN_4) ? ep_ir_ff[ep_idx] :
                          (sfr_req.addr == `USBS_WIN_5) ? ep_ba_ff[ep_idx] :
                          (sfr_req.addr == `USBS_WIN_6) ? ep_len_ff[ep_idx] : `USBS_BYTE_ZERO;
    wire [7:0] win_rdata = dev_sel ? dev_rdata : ep_sel ? ep_rdata : `USBS_BYTE_ZERO;
    wire in_window = (sfr_req.addr >= `USBS_WIN_1) && (sfr_req.addr <= `USBS_WIN_7);

    assign sfr_rdata = !sfr_req.rd ? `USBS_BYTE_ZERO :
                       in_window ? win_rdata :
                       (sfr_req.addr == `USBS_ADDR_SELECT) ? select_ff :
                       (sfr_req.addr == `USBS_ADDR_DATA) ? data_ff :
                       (sfr_req.addr == `USBS_ADDR_OFFSET) ? {2'b00, offset_ff} :
                       (sfr_req.addr == `USBS_ADDR_SUMMARY) ? summary_value : `USBS_BYTE_ZERO;

    assign device_control = dev_ctl_ff;
    assign device_power_down = dev_pwr_ff;
    assign device_irq_enable = dev_ien_ff;
    assign global_ep_irq_summary = summary_value;

    // --------------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_offset_moves;
        nxt_fetch_pend;
    endsequence
    sequence s_fetch_lands;
        // Case equality: unwritten buffer bytes are unknown and still travel into the data port
        fetch_pend_ff ##1 (data_ff === $past(mem_rdata));
    endsequence

    dev_decode_a: assert property (dev_sel && sfr_req.rd && sfr_req.addr == `USBS_WIN_4 |-> sfr_rdata == dev_irq_ff)
        else $error("device irq request not on window slot four");
    ep_decode_a: assert property (ep_sel && sfr_req.rd && sfr_req.addr == `USBS_WIN_5 |-> sfr_rdata == ep_ba_ff[ep_num])
        else $error("endpoint base address not on window slot five");
    data_read_a: assert property (rd_data |-> sfr_rdata == data_ff)
        else $error("data port read does not return the held byte");
    write_gate_a: assert property (wr_offset && !gate_ok && !offset_step |=> $stable(offset_ff))
        else $error("offset write accepted against the gate");
    data_gate_a: assert property (wr_data && !gate_ok |-> !u_usbs_buf_mem.we)
        else $error("data write reached memory against the gate");
    fault_flag_a: assert property (fault_event |=> ep_ir_ff[$past(ep_idx)][`USBS_FAULT_BIT])
        else $error("no-data fault flag not raised");
    offset_upper_a: assert property (sfr_req.rd && sfr_req.addr == `USBS_ADDR_OFFSET |-> sfr_rdata[7:6] == 2'b00)
        else $error("offset upper bits read nonzero");
    prefetch_land_a: assert property (s_offset_moves |=> s_fetch_lands)
        else $error("prefetch did not load the new byte");
    offset_step_a: assert property (data_wr_ok && !offset_wr_ok |=> offset_ff == $past(offset_ff) + `USBS_OFF_ONE)
        else $error("offset did not advance after a data write");
    summary_set_a: assert property (|ep_ir_set_all[0] |=> summary_ff[0])
        else $error("summary flag not set by endpoint request");
    summary_clear_a: assert property (g_ep[1].ir_read && !(|ep_ir_set_all[1]) |=> !summary_ff[1])
        else $error("summary flag not cleared by request register read");
    dev_req_keep_a: assert property (dev_req_ff && !(wr_summary && !sfr_req.wdata[`USBS_REQ_BIT])
        |=> dev_req_ff)
        else $error("device-request flag lost without a zero write");
    device_only_a: assert property (!dev_sel && !ep_sel && sfr_req.rd && in_window |-> sfr_rdata == 8'h00)
        else $error("window answered with no valid block selected");

endmodule
`default_nettype wire

// file: design/usbs_params.svh
// Constants for the USB special-function-register bank: addresses, reset values, field positions.
// Assumes inclusion by the package and by every design file that decodes the CPU bus.
`ifndef USBS_PARAMS_SVH
`define USBS_PARAMS_SVH

// --------------------------------------------------------------------------
// Global register addresses
// --------------------------------------------------------------------------
`define USBS_ADDR_SELECT 8'hD2
`define USBS_ADDR_DATA 8'hD3
`define USBS_ADDR_OFFSET 8'hD4
`define USBS_ADDR_SUMMARY 8'hD6

// --------------------------------------------------------------------------
// Shared window addresses
// --------------------------------------------------------------------------
`define USBS_WIN_1 8'hC1
`define USBS_WIN_2 8'hC2
`define USBS_WIN_3 8'hC3
`define USBS_WIN_4 8'hC4
`define USBS_WIN_5 8'hC5
`define USBS_WIN_6 8'hC6
`define USBS_WIN_7 8'hC7

// --------------------------------------------------------------------------
// Reset values, masks and field positions
// --------------------------------------------------------------------------
`define USBS_SELECT_RESET 8'h80
`define USBS_SELECT_DEVICE 8'h80
`define USBS_SELECT_MASK 8'h87
`define USBS_SELECT_TOP 7
`define USBS_BYTE_ZERO 8'h00
`define USBS_EP_COUNT 5
`define USBS_EP_LAST 3'h4
`define USBS_OFF_BITS 6
`define USBS_OFF_ONE 6'h01
`define USBS_FAULT_BIT 0
`define USBS_REQ_BIT 7
`define USBS_MEM_DEPTH 256

`endif

// file: design/usbs_pkg.sv
// Types shared by the USB special-function-register bank.
// Assumes the constants header sits beside it on the include path.
`include "usbs_params.svh"

package usbs_pkg;

    // CPU special-function-register bus request, one access per cycle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usbs_sfr_req_type;

    // Per-endpoint transfer state supplied by the USB engine
    typedef struct packed {
        logic [`USBS_EP_COUNT-1:0] dir;
        logic [`USBS_EP_COUNT-1:0] cpu_buffer_full;
    } usbs_ep_state_type;

endpackage

// file: design/usbs_buf_mem.sv
// USB buffer memory: one write port and one asynchronous read port on the same address.
// Assumes the caller forms the byte address from endpoint base and offset.
`timescale 1ns/1ns
`default_nettype none
`include "usbs_params.svh"

module usbs_buf_mem (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    import usbs_pkg::*;

    // --------------------------------------------------------------------------
    // Storage: two 128-byte pages, no reset so it maps onto plain RAM
    // --------------------------------------------------------------------------
    logic [7:0] mem_array [`USBS_MEM_DEPTH];

    // Write on the clock edge
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem_array[addr] <= wdata;
        end
    end

    // Asynchronous read lets the prefetch land one cycle after the pointer moves
    assign rdata = mem_array[addr];

endmodule
`default_nettype wire

// file: dv/usbs_cpu.sv
// Behavioural CPU core that issues special-function-register reads and writes to the bank.
// Assumes one access per cycle on sys_clk, read data valid combinationally while rd is high.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// CPU bus master model
// ----------------------------------------------------------------------
module usbs_cpu (
    input wire logic sys_clk,
    input wire logic [7:0] sfr_rdata,
    output var usbs_pkg::usbs_sfr_req_type sfr_req
);
    import usbs_pkg::*;

    // Bus idle from time zero so no access precedes reset release
    initial begin
        sfr_req = '0;
    end

    // One access, then one idle cycle; every byte is staged in a variable first,
    // so no immediate-operand write ever reaches the data port back to back
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        sfr_req.addr = a;
        sfr_req.wdata = d;
        sfr_req.wr = w;
        sfr_req.rd = !w;
        @(posedge sys_clk);
        q = sfr_rdata; // Taken at the accepting edge, before the bank's flops update
        #1;
        sfr_req = '0;
        @(posedge sys_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// file: dv/test_usbs_sfr_bank.sv
// Self-checking bench for the USB register bank: window decode, buffer port, offset, summary flags.
// Assumes the CPU model drives the bus and the bench drives the USB engine side directly.
`timescale 1ns/1ns
`default_nettype none

module test_usbs_sfr_bank;
    import usbs_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    usbs_sfr_req_type sfr_req;
    usbs_ep_state_type ep_st = '0;
    logic [7:0] sfr_rdata, q, dev_ctl, dev_pd, dev_ie, summary;
    logic [4:0][7:0] ep_irq_set = '0, ep_bc, ep_bs, ep_ie, ep_len;
    logic [7:0] dev_irq_set = 8'h00;
    logic dev_req_set = 1'b0;
    logic [15:0] frame_number = 16'hA53C;
    int bad_count = 0, checked = 0, cycles = 0;

    usbs_sfr_bank u_usbs_sfr_bank (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .ep_state(ep_st), .ep_irq_set(ep_irq_set), .dev_irq_set(dev_irq_set),
        .dev_req_set(dev_req_set), .frame_number(frame_number), .ep_buffer_control(ep_bc),
        .ep_buffer_status(ep_bs), .ep_irq_enable(ep_ie), .ep_buffer_length(ep_len),
        .device_control(dev_ctl), .device_power_down(dev_pd), .device_irq_enable(dev_ie),
        .global_ep_irq_summary(summary));
    usbs_cpu u_usbs_cpu (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req));

    // ------------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------------
    always #2 sys_clk = ~sys_clk;

    // The full run needs well under a thousand cycles; the ceiling leaves slack
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_usbs_cpu.access(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        u_usbs_cpu.access(1'b0, a, 8'h00, q);
        check_byte(what, exp, q);
    endtask

    // Waits whole cycles and lands just after the edge, where inputs change
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        idle(6);
        sys_rst = 1'b0;
        rd(8'hD2, 8'h80, "select reset");
        rd(8'hD3, 8'h00, "data reset");
        rd(8'hD4, 8'h00, "offset reset");
        rd(8'hD6, 8'h00, "summary reset");
        $display("test reset values done");
        // Device block: registers, frame number, reserved slot, request register
        wr(8'hD2, 8'h80);
        wr(8'hC1, 8'h5A);
        wr(8'hC2, 8'h3C);
        wr(8'hC3, 8'hC3);
        check_byte("device control", 8'h5A, dev_ctl);
        check_byte("device power down", 8'h3C, dev_pd);
        check_byte("device irq enable", 8'hC3, dev_ie);
        rd(8'hC6, 8'h3C, "frame low");
        rd(8'hC7, 8'hA5, "frame high");
        rd(8'hC5, 8'h00, "device reserved");
        dev_irq_set = 8'h04;
        idle(1);
        dev_irq_set = 8'h00;
        rd(8'hC4, 8'h04, "device irq request");
        wr(8'hD2, 8'h81);
        wr(8'hC1, 8'hA5);
        check_byte("device control kept", 8'h5A, dev_ctl);
        rd(8'hC6, 8'h00, "frame hidden");
        $display("test device block done");
        // Every endpoint block; endpoint e gets base e*48
        for (int e = 0; e < 5; e++) begin
            wr(8'hD2, 8'(e));
            wr(8'hC1, 8'h30 + 8'(e));
            wr(8'hC2, 8'h50 + 8'(e));
            wr(8'hC3, 8'h70 + 8'(e));
            wr(8'hC5, 8'(e * 48));
            wr(8'hC6, 8'h90 + 8'(e));
            check_byte("ep buffer control", 8'h30 + 8'(e), ep_bc[e]);
            check_byte("ep buffer status", 8'h50 + 8'(e), ep_bs[e]);
            check_byte("ep irq enable", 8'h70 + 8'(e), ep_ie[e]);
            check_byte("ep buffer length", 8'h90 + 8'(e), ep_len[e]);
            rd(8'hC5, 8'(e * 48), "ep base");
            rd(8'hC7, 8'h00, "ep reserved");
        end
        wr(8'hD2, 8'h05);
        rd(8'hC1, 8'h00, "endpoint five");
        $display("test endpoint blocks done");
        // Buffer path on endpoint 1: write with dir 0 and full set, read with dir 1 and full clear
        ep_st.cpu_buffer_full = 5'h1F;
        wr(8'hD2, 8'h01);
        wr(8'hD4, 8'hFE);
        rd(8'hD4, 8'h3E, "offset upper bits");
        wr(8'hD3, 8'hA1);
        wr(8'hD3, 8'hB2);
        wr(8'hD3, 8'hC3);
        rd(8'hD4, 8'h01, "offset wrapped");
        ep_st.dir[1] = 1'b1;
        ep_st.cpu_buffer_full[1] = 1'b0;
        wr(8'hD4, 8'h3E);
        idle(2);
        rd(8'hD3, 8'hA1, "prefetch after offset write");
        idle(2);
        rd(8'hD3, 8'hB2, "prefetch after step");
        idle(2);
        rd(8'hD3, 8'hC3, "wrapped byte");
        $display("test buffer path done");
        // A refused data write raises the fault flag and the summary bit; the refused offset write only leaves the offset
        wr(8'hD4, 8'h00);
        ep_st.cpu_buffer_full[1] = 1'b1;
        wr(8'hD3, 8'h77);
        wr(8'hD4, 8'h10);
        rd(8'hD4, 8'h00, "offset refused");
        rd(8'hD6, 8'h02, "summary fault");
        rd(8'hC4, 8'h01, "no data fault");
        rd(8'hD6, 8'h00, "summary cleared");
        ep_st.cpu_buffer_full[1] = 1'b0;
        wr(8'hD4, 8'h00);
        idle(2);
        rd(8'hD3, 8'hC3, "refused write");
        ep_irq_set[3] = 8'h20;
        idle(1);
        ep_irq_set = '0;
        rd(8'hD6, 8'h08, "summary ep3");
        wr(8'hD2, 8'h03);
        rd(8'hC4, 8'h20, "ep3 request");
        rd(8'hD6, 8'h00, "summary ep3 cleared");
        $display("test refusals and summary done");
        // Device-request flag: only a written zero clears it
        dev_req_set = 1'b1;
        idle(1);
        dev_req_set = 1'b0;
        rd(8'hD6, 8'h80, "request flag set");
        check_byte("summary output", 8'h80, summary);
        wr(8'hD6, 8'hFF);
        rd(8'hD6, 8'h80, "request flag kept");
        wr(8'hD6, 8'h00);
        rd(8'hD6, 8'h00, "request flag cleared");
        $display("test device request flag done");
        report_and_stop();
    end
endmodule
`default_nettype wire
